// ### include/gia_pkg.sv
// constants and types for the group interrupt arm unit
// assumes one processor clock domain; levels numbered from octal 200 upward
package gia_pkg;
  localparam int LEVELS_PER_GROUP = 16;
  localparam int MAX_GROUPS = 56;
  localparam logic [5:0] FITTED_GROUPS = 6'h38;
  localparam int GRP_W = 6;
  localparam int BIT_W = 4;
  localparam int LVL_W = 10;
  localparam int CW_W = 24;
  localparam int WORD_W = 32;
  localparam int CW_GRP_LSB = 18;
  localparam int CW_FN_MSB = 17;
  localparam int CW_FN_LSB = 16;
  localparam int CW_MASK_MSB = 15;
  localparam int WAIT_LSB = 16;
  localparam logic [LVL_W-1:0] LEVEL_BASE = 10'h080;
  localparam logic [1:0] FN_NONE = 2'h0;
  localparam logic [1:0] FN_ARM = 2'h1;
  localparam logic [1:0] FN_DISARM = 2'h2;
  localparam logic [1:0] FN_SET = 2'h3;
  localparam logic [15:0] ALL_ARMED = 16'hffff;
  typedef enum logic [1:0] {
    GIA_IDLE = 2'h0,
    GIA_ACC = 2'h1,
    GIA_CLR = 2'h3
  } gia_state_t;
  typedef enum logic [1:0] {
    GIA_OP_CW = 2'h0,
    GIA_OP_PULSE = 2'h1,
    GIA_OP_SCAN = 2'h2
  } gia_op_t;
endpackage

// ### hdl/gia_mem.sv
// per-group store: armed bits low half, waiting bits high half
// one read and one write port, read data registered
`timescale 1ns/1ps
module gia_mem (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic rd_en,
  input wire logic [gia_pkg::GRP_W-1:0] rd_addr,
  input wire logic wr_en,
  input wire logic [gia_pkg::GRP_W-1:0] wr_addr,
  input wire logic [gia_pkg::WORD_W-1:0] wr_data,
  output logic [gia_pkg::WORD_W-1:0] rd_data_r
);
  logic [gia_pkg::WORD_W-1:0] mem [gia_pkg::MAX_GROUPS];

  always_ff @(posedge clk) begin
    if (ce && wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_data_r <= '0;
    end else if (ce && rd_en) begin
      rd_data_r <= mem[rd_addr];
    end
  end
endmodule

// ### hdl/gia_top.sv
// arm control unit for the special-system interrupt levels
// core strobes are on clk; console start and unit-present strap are pins
//
// Overview of operation
// RULE1: levels exist only in whole groups of sixteen, up to the fitted group count.
// RULE2: with the unit absent every level acts as armed and control words are ignored.
// RULE3: a pulse to an armed level always makes that level wait.
// RULE4: levels count as enabled only while the global interrupt-enabled input is high.
// RULE5: arming changes only per group and only by a prepare command then an output word.
// RULE6: console start clears every level to disarmed, not waiting and not active.
// RULE7: the prepare command primes the unit for the next output word in one cycle.
// RULE8: the core must issue a prepare before each control-word output.
// RULE9: the arm path neither reads nor changes the global enable.
// RULE10: control word bits 0 to 5 pick the group, zero meaning levels from octal 200.
// RULE11: control word bits 8 to 23 are the mask, bit 8 for the group's first level.
// RULE12: function 01 arms the levels with a one mask bit and keeps the rest.
// RULE13: function 10 disarms the levels with a zero mask bit and keeps the rest.
// RULE14: function 11 arms the one-bit levels and disarms the zero-bit levels.
// RULE15: function 00 leaves the group unchanged.
// RULE16: a pulse to a disarmed level is dropped and not remembered.
// RULE17: a waiting level goes active only when enabled and nothing higher is active.
`timescale 1ns/1ps
module gia_top (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic unit_present,
  input wire logic console_start,
  input wire logic global_irq_enabled,
  input wire logic arm_prepare_command,
  input wire logic parallel_output_transfer,
  input wire logic [gia_pkg::CW_W-1:0] xfer_word,
  input wire logic irq_pulse_stb,
  input wire logic [gia_pkg::LVL_W-1:0] irq_pulse_level,
  input wire logic active_clear,
  output logic prep_done_r,
  output logic arm_unit_primed_r,
  output logic pulse_ready_r,
  output logic active_valid_r,
  output logic [gia_pkg::LVL_W-1:0] active_level_r
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  logic start_s1_r, start_s2_r, present_s1_r, present_s2_r;
  gia_pkg::gia_state_t state_r, state_nxt;
  gia_pkg::gia_op_t op_r, op_nxt;
  logic clr_pend_r, cw_pend_r, pulse_pend_r;
  logic [gia_pkg::CW_W-1:0] cw_r, acc_cw_r;
  logic [gia_pkg::GRP_W-1:0] pulse_grp_r, op_grp_r, scan_grp_r, clr_idx_r;
  logic [gia_pkg::BIT_W-1:0] pulse_bit_r, op_bit_r;
  logic rd_en, wr_en;
  logic [gia_pkg::GRP_W-1:0] rd_addr, wr_addr;
  logic [gia_pkg::WORD_W-1:0] wr_data, rd_data_r;
  logic [15:0] mask, armed_cur, armed_eff, wait_cur, armed_new, wait_new;
  logic [1:0] fn;
  logic found;
  logic [gia_pkg::BIT_W-1:0] found_bit;
  logic [gia_pkg::LVL_W-1:0] rel_level;
  logic pulse_take, pulse_ok, dispatch;

  // two-stage synchronisers for the console button and the strap
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      start_s1_r <= 1'b0;
      start_s2_r <= 1'b0;
      present_s1_r <= 1'b0;
      present_s2_r <= 1'b0;
    end else if (ce) begin
      start_s1_r <= console_start;
      start_s2_r <= start_s1_r;
      present_s1_r <= unit_present;
      present_s2_r <= present_s1_r;
    end
  end

  gia_mem u_mem (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .rd_en(rd_en),
    .rd_addr(rd_addr),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .rd_data_r(rd_data_r)
  );

  // mask bit 8 of the word (msb-first numbering) maps to level 0 of the group
  for (genvar k = 0; k < gia_pkg::LEVELS_PER_GROUP; k++) begin : g_mask
    assign mask[k] = acc_cw_r[gia_pkg::CW_MASK_MSB-k]; // RULE11
  end
  assign fn = acc_cw_r[gia_pkg::CW_FN_MSB:gia_pkg::CW_FN_LSB];
  assign armed_cur = rd_data_r[gia_pkg::WAIT_LSB-1:0];
  assign wait_cur = rd_data_r[gia_pkg::WORD_W-1:gia_pkg::WAIT_LSB];
  assign armed_eff = present_s2_r ? armed_cur : gia_pkg::ALL_ARMED; // RULE2
  assign rel_level = irq_pulse_level - gia_pkg::LEVEL_BASE;
  assign pulse_ok = (irq_pulse_level >= gia_pkg::LEVEL_BASE)
                    && (rel_level[gia_pkg::LVL_W-1:gia_pkg::BIT_W] < gia_pkg::FITTED_GROUPS); // RULE1
  assign pulse_take = irq_pulse_stb && pulse_ready_r;

  // new contents of the group being visited
  always_comb begin
    armed_new = armed_cur;
    wait_new = wait_cur;
    found = 1'b0;
    found_bit = '0;
    for (int i = gia_pkg::LEVELS_PER_GROUP - 1; i >= 0; i--) begin
      if (wait_cur[i]) begin
        found = 1'b1;
        found_bit = i[gia_pkg::BIT_W-1:0];
      end
    end
    case (op_r)
      gia_pkg::GIA_OP_CW: begin
        case (fn)
          gia_pkg::FN_ARM: armed_new = armed_cur | mask; // RULE12
          gia_pkg::FN_DISARM: armed_new = armed_cur & mask; // RULE13
          gia_pkg::FN_SET: armed_new = mask; // RULE14
          default: armed_new = armed_cur; // RULE15
        endcase
      end
      gia_pkg::GIA_OP_PULSE: begin
        wait_new[op_bit_r] = wait_cur[op_bit_r] | armed_eff[op_bit_r]; // RULE3 RULE16
      end
      gia_pkg::GIA_OP_SCAN: begin
        if (found && global_irq_enabled && !active_valid_r) begin
          wait_new[found_bit] = 1'b0;
        end
      end
      default: armed_new = armed_cur;
    endcase
  end

  // single-port sequencer: clear, control word, pulse, then priority scan
  always_comb begin
    state_nxt = state_r;
    op_nxt = op_r;
    rd_en = 1'b0;
    rd_addr = scan_grp_r;
    wr_en = 1'b0;
    wr_addr = op_grp_r;
    wr_data = {wait_new, armed_new};
    dispatch = 1'b0;
    case (state_r)
      gia_pkg::GIA_IDLE: begin
        if (clr_pend_r) begin
          state_nxt = gia_pkg::GIA_CLR;
        end else if (cw_pend_r) begin
          rd_en = 1'b1;
          rd_addr = cw_r[gia_pkg::CW_W-1:gia_pkg::CW_GRP_LSB]; // RULE10
          op_nxt = gia_pkg::GIA_OP_CW;
          dispatch = 1'b1;
          state_nxt = gia_pkg::GIA_ACC;
        end else if (pulse_pend_r) begin
          rd_en = 1'b1;
          rd_addr = pulse_grp_r;
          op_nxt = gia_pkg::GIA_OP_PULSE;
          dispatch = 1'b1;
          state_nxt = gia_pkg::GIA_ACC;
        end else if (global_irq_enabled && !active_valid_r) begin // RULE4 RULE17
          rd_en = 1'b1;
          op_nxt = gia_pkg::GIA_OP_SCAN;
          dispatch = 1'b1;
          state_nxt = gia_pkg::GIA_ACC;
        end
      end
      gia_pkg::GIA_ACC: begin
        wr_en = 1'b1;
        state_nxt = gia_pkg::GIA_IDLE;
      end
      gia_pkg::GIA_CLR: begin
        wr_en = 1'b1;
        wr_addr = clr_idx_r;
        wr_data = '0; // RULE6
        if (clr_idx_r == gia_pkg::FITTED_GROUPS - 6'h01) begin
          state_nxt = gia_pkg::GIA_IDLE;
        end
      end
      default: state_nxt = gia_pkg::GIA_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= gia_pkg::GIA_IDLE;
      op_r <= gia_pkg::GIA_OP_CW;
      clr_pend_r <= 1'b1;
      clr_idx_r <= '0;
      op_grp_r <= '0;
      op_bit_r <= '0;
      acc_cw_r <= '0;
    end else if (ce) begin
      state_r <= state_nxt;
      op_r <= op_nxt;
      if (start_s2_r) begin
        clr_pend_r <= 1'b1; // RULE6
      end else if (state_r == gia_pkg::GIA_IDLE) begin
        clr_pend_r <= 1'b0;
      end
      if (state_r == gia_pkg::GIA_CLR) begin
        clr_idx_r <= clr_idx_r + 6'h01;
      end else begin
        clr_idx_r <= '0;
      end
      if (dispatch) begin
        op_grp_r <= rd_addr;
        op_bit_r <= pulse_bit_r;
        acc_cw_r <= cw_r;
      end
    end
  end

  // prepare command and control word capture
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      arm_unit_primed_r <= 1'b0;
      prep_done_r <= 1'b0;
      cw_pend_r <= 1'b0;
      cw_r <= '0;
    end else if (ce) begin
      prep_done_r <= arm_prepare_command; // RULE7
      if (start_s2_r || state_r == gia_pkg::GIA_CLR) begin
        arm_unit_primed_r <= 1'b0;
        cw_pend_r <= 1'b0;
      end else begin
        if (dispatch && op_nxt == gia_pkg::GIA_OP_CW) begin
          cw_pend_r <= 1'b0;
        end
        if (arm_prepare_command) begin
          arm_unit_primed_r <= 1'b1; // RULE7
        end else if (parallel_output_transfer && arm_unit_primed_r && present_s2_r) begin
          arm_unit_primed_r <= 1'b0; // RULE5 RULE8
          if (!cw_pend_r
              && xfer_word[gia_pkg::CW_W-1:gia_pkg::CW_GRP_LSB] < gia_pkg::FITTED_GROUPS) begin
            cw_pend_r <= 1'b1; // RULE5
            cw_r <= xfer_word; // RULE9
          end
        end
      end
    end
  end

  // one-slot holding register for an incoming pulse
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pulse_pend_r <= 1'b0;
      pulse_ready_r <= 1'b0;
      pulse_grp_r <= '0;
      pulse_bit_r <= '0;
    end else if (ce) begin
      if (pulse_take && pulse_ok) begin
        pulse_pend_r <= 1'b1;
        pulse_ready_r <= 1'b0;
        pulse_grp_r <= rel_level[gia_pkg::LVL_W-1:gia_pkg::BIT_W];
        pulse_bit_r <= rel_level[gia_pkg::BIT_W-1:0];
      end else if (state_r == gia_pkg::GIA_CLR
                   || (dispatch && op_nxt == gia_pkg::GIA_OP_PULSE)) begin
        pulse_pend_r <= 1'b0;
        pulse_ready_r <= 1'b1;
      end else begin
        pulse_ready_r <= !pulse_pend_r;
      end
    end
  end

  // active level and round-robin scan pointer
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      active_valid_r <= 1'b0;
      active_level_r <= '0;
      scan_grp_r <= '0;
    end else if (ce) begin
      if (start_s2_r || active_clear) begin
        active_valid_r <= 1'b0; // RULE6
      end else if (state_r == gia_pkg::GIA_ACC && op_r == gia_pkg::GIA_OP_SCAN
                   && found && global_irq_enabled && !active_valid_r) begin
        active_valid_r <= 1'b1; // RULE17
        active_level_r <= gia_pkg::LEVEL_BASE + {op_grp_r, found_bit};
      end
      if (state_r == gia_pkg::GIA_CLR) begin
        scan_grp_r <= '0;
      end else if (state_r == gia_pkg::GIA_ACC && op_r == gia_pkg::GIA_OP_SCAN && !found) begin
        scan_grp_r <= (scan_grp_r == gia_pkg::FITTED_GROUPS - 6'h01) ? '0 : scan_grp_r + 6'h01;
      end
    end
  end

  wire acc_cw = state_r == gia_pkg::GIA_ACC && op_r == gia_pkg::GIA_OP_CW;
  wire acc_pl = state_r == gia_pkg::GIA_ACC && op_r == gia_pkg::GIA_OP_PULSE;

  property p_prep_one_cycle;
    arm_prepare_command && ce && !start_s2_r && state_r != gia_pkg::GIA_CLR
      |=> prep_done_r && arm_unit_primed_r;
  endproperty
  a_prep_one_cycle: assert property (p_prep_one_cycle) else $error("prepare not done in one cycle"); // RULE7
  property p_pot_needs_prep;
    parallel_output_transfer && !arm_unit_primed_r && !cw_pend_r && ce |=> !cw_pend_r;
  endproperty
  a_pot_needs_prep: assert property (p_pot_needs_prep) else $error("word taken without prepare"); // RULE8
  property p_absent_ignores;
    !present_s2_r && !cw_pend_r |=> !cw_pend_r;
  endproperty
  a_absent_ignores: assert property (p_absent_ignores) else $error("word taken with unit absent"); // RULE2
  property p_fn_arm;
    acc_cw && fn == gia_pkg::FN_ARM |-> wr_en && wr_data[15:0] == (armed_cur | mask);
  endproperty
  a_fn_arm: assert property (p_fn_arm) else $error("arm function wrong"); // RULE12
  property p_fn_disarm;
    acc_cw && fn == gia_pkg::FN_DISARM |-> wr_data[15:0] == (armed_cur & mask);
  endproperty
  a_fn_disarm: assert property (p_fn_disarm) else $error("disarm function wrong"); // RULE13
  property p_fn_set;
    acc_cw && fn == gia_pkg::FN_SET |-> wr_data[15:0] == mask && wr_addr == op_grp_r;
  endproperty
  a_fn_set: assert property (p_fn_set) else $error("set function wrong"); // RULE14
  property p_fn_none;
    acc_cw && fn == gia_pkg::FN_NONE |-> wr_data == rd_data_r;
  endproperty
  a_fn_none: assert property (p_fn_none) else $error("unused code changed group"); // RULE15
  property p_pulse_armed;
    acc_pl && armed_eff[op_bit_r] |-> wr_data[gia_pkg::WAIT_LSB + op_bit_r];
  endproperty
  a_pulse_armed: assert property (p_pulse_armed) else $error("armed pulse not waiting"); // RULE3
  property p_pulse_disarmed;
    acc_pl && !armed_eff[op_bit_r] |-> wr_data == rd_data_r;
  endproperty
  a_pulse_disarmed: assert property (p_pulse_disarmed) else $error("disarmed pulse kept"); // RULE16
  property p_active_enabled;
    $rose(active_valid_r) |-> $past(global_irq_enabled) && $past(state_r) == gia_pkg::GIA_ACC;
  endproperty
  a_active_enabled: assert property (p_active_enabled) else $error("activation while disabled"); // RULE4
  property p_start_clears;
    start_s2_r && ce |=> !active_valid_r ##[0:2] state_r == gia_pkg::GIA_CLR;
  endproperty
  a_start_clears: assert property (p_start_clears) else $error("start did not clear"); // RULE6

  c_arm_word: cover property (acc_cw && fn == gia_pkg::FN_SET);
  c_pulse_kept: cover property (acc_pl && armed_eff[op_bit_r]);
  c_activate: cover property ($rose(active_valid_r));
endmodule

// ### dv/gia_core_model.sv
// processor core model: prepare strobes, control words, interrupt pulses, active clear
// assumes callers enter each task just after a rising edge of clk
`timescale 1ns/1ps
module gia_core_model (
  input wire logic clk,
  input wire logic pulse_ready_r,
  output logic arm_prepare_command,
  output logic parallel_output_transfer,
  output logic [gia_pkg::CW_W-1:0] xfer_word,
  output logic irq_pulse_stb,
  output logic [gia_pkg::LVL_W-1:0] irq_pulse_level,
  output logic active_clear
);
  initial begin
    arm_prepare_command = 1'b0;
    parallel_output_transfer = 1'b0;
    xfer_word = 24'h000000;
    irq_pulse_stb = 1'b0;
    irq_pulse_level = 10'h000;
    active_clear = 1'b0;
  end
  task automatic step();
    @(posedge clk);
    #1;
  endtask
  task automatic prepare();
    arm_prepare_command = 1'b1;
    step();
    arm_prepare_command = 1'b0;
  endtask
  // gap idles the core between prepare and word, the slow case
  task automatic send_word(input logic [23:0] w, input int gap);
    repeat (gap) step();
    parallel_output_transfer = 1'b1;
    xfer_word = w;
    step();
    parallel_output_transfer = 1'b0;
    xfer_word = ~w;
  endtask
  // request held until an edge sees pulse_ready_r high
  task automatic pulse(input logic [9:0] lvl);
    irq_pulse_stb = 1'b1;
    irq_pulse_level = lvl;
    while (pulse_ready_r !== 1'b1) step();
    step();
    irq_pulse_stb = 1'b0;
    irq_pulse_level = ~lvl;
    step();
  endtask
  task automatic clear();
    active_clear = 1'b1;
    step();
    active_clear = 1'b0;
  endtask
endmodule

// ### dv/gia_top_tb_top.sv
// self-checking bench for the group interrupt arm unit
// assumes gia_core_model drives the core side; expectations kept per group
`timescale 1ns/1ps
module gia_top_tb_top;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic ce = 1'b1;
  logic unit_present = 1'b1;
  logic console_start = 1'b0;
  logic global_irq_enabled = 1'b1;
  logic prep, xfer, stb, aclr;
  logic [23:0] pdat;
  logic [9:0] plvl;
  logic prep_done_r, arm_unit_primed_r, pulse_ready_r, active_valid_r;
  logic [9:0] active_level_r;
  logic [15:0] exp_arm [56];
  logic [31:0] r;
  logic [5:0] g;
  int n_fail = 0;
  int tests_run = 0;
  int cyc = 0;
  integer seed = 32'h30c0;
  localparam logic [9:0] B = gia_pkg::LEVEL_BASE;

  always #12.5 clk = ~clk;

  gia_core_model core (.clk(clk), .pulse_ready_r(pulse_ready_r), .arm_prepare_command(prep),
    .parallel_output_transfer(xfer), .xfer_word(pdat), .irq_pulse_stb(stb),
    .irq_pulse_level(plvl), .active_clear(aclr));

  gia_top dut (.clk(clk), .rst_b(rst_b), .ce(ce), .unit_present(unit_present),
    .console_start(console_start), .global_irq_enabled(global_irq_enabled),
    .arm_prepare_command(prep), .parallel_output_transfer(xfer), .xfer_word(pdat),
    .irq_pulse_stb(stb), .irq_pulse_level(plvl), .active_clear(aclr),
    .prep_done_r(prep_done_r), .arm_unit_primed_r(arm_unit_primed_r),
    .pulse_ready_r(pulse_ready_r), .active_valid_r(active_valid_r),
    .active_level_r(active_level_r));

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      n_fail++;
      give_verdict();
    end
  end

  task automatic chk(input logic [23:0] seen, input logic [23:0] want);
    tests_run++;
    if (seen !== want) begin
      n_fail++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, want);
    end
  endtask

  task automatic cyc_wait(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  function automatic logic [15:0] next_arm(input logic [15:0] old, input logic [1:0] fn,
                                           input logic [15:0] m);
    case (fn)
      gia_pkg::FN_ARM: return old | m;
      gia_pkg::FN_DISARM: return old & m;
      gia_pkg::FN_SET: return m;
      default: return old;
    endcase
  endfunction

  // m bit b stands for level b of the group; the word carries it msb-first
  task automatic arm(input logic [5:0] gr, input logic [1:0] fn, input logic [15:0] m,
                     input int gap);
    logic [15:0] rv;
    for (int i = 0; i < 16; i++) rv[15-i] = m[i];
    core.prepare();
    chk(prep_done_r, 24'h1);
    chk(arm_unit_primed_r, 24'h1);
    core.send_word({gr, fn, rv}, gap);
    if (unit_present) exp_arm[gr] = next_arm(exp_arm[gr], fn, m);
    cyc_wait(10);
  endtask

  task automatic wait_act();
    int n;
    n = 0;
    while (active_valid_r !== 1'b1 && n < 130) begin
      cyc_wait(1);
      n++;
    end
  endtask

  task automatic probe(input logic [9:0] lvl, input logic want);
    core.pulse(lvl);
    wait_act();
    chk(active_valid_r, want);
    if (active_valid_r === 1'b1) begin
      chk(active_level_r, lvl);
      core.clear();
      cyc_wait(2);
    end
  endtask

  task automatic check_group(input logic [5:0] gr, input logic absent);
    for (int b = 0; b < 16; b++) probe(B + {gr, 4'(b)}, absent | exp_arm[gr][b]);
  endtask

  initial begin
    for (int i = 0; i < 56; i++) exp_arm[i] = 16'h0000;
    repeat (10) @(posedge clk);
    #1;
    rst_b = 1'b1;
    cyc_wait(64);
    // every function code on one group, each followed by a full sweep
    for (int f = 0; f < 4; f++) begin
      arm(6'h01, 2'(f), 16'h0f35 ^ 16'(f * 16'h1111), f);
      check_group(6'h01, 1'b0);
    end
    // a word with no prepare in front of it changes nothing
    core.send_word(24'h0bffff, 0);
    cyc_wait(10);
    check_group(6'h02, 1'b0);
    // arming while disabled, then waiting levels released in order
    global_irq_enabled = 1'b0;
    arm(6'h00, gia_pkg::FN_SET, 16'h0028, 0);
    core.pulse(B + 10'h005);
    core.pulse(B + 10'h003);
    cyc_wait(130);
    chk(active_valid_r, 24'h0);
    global_irq_enabled = 1'b1;
    wait_act();
    chk(active_level_r, B + 10'h003);
    core.clear();
    wait_act();
    chk(active_level_r, B + 10'h005);
    core.clear();
    cyc_wait(2);
    // unit absent: all armed, words ignored
    unit_present = 1'b0;
    cyc_wait(4);
    arm(6'h03, gia_pkg::FN_DISARM, 16'h0000, 0);
    check_group(6'h03, 1'b1);
    unit_present = 1'b1;
    cyc_wait(4);
    // random words with a probe of one level of the addressed group
    repeat (24) begin
      r = $random(seed);
      g = 6'(r[15:0] % 16'd56);
      arm(g, r[17:16], 16'($random(seed)), int'(r[19:18]));
      probe(B + {g, r[23:20]}, exp_arm[g][r[23:20]]);
    end
    // console start drops the active level and disarms everything
    arm(6'h04, gia_pkg::FN_SET, 16'hffff, 0);
    core.pulse(B + 10'h040);
    wait_act();
    console_start = 1'b1;
    cyc_wait(4);
    console_start = 1'b0;
    cyc_wait(70);
    chk(active_valid_r, 24'h0);
    for (int i = 0; i < 56; i++) exp_arm[i] = 16'h0000;
    check_group(6'h04, 1'b0);
    give_verdict();
  end
endmodule
